// ---- rtl/emulator_run_state_gating.sv ----
// Run-state gating of target pins, clock choice and memory routing
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module emulator_run_state_gating #(
	parameter int SYNC_STAGES = 3
) (
	input  wire logic                    sys_clk,
	input  wire logic                    nrst,
	input  wire logic [3:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	input  wire run_gate_pkg::target_in_t targetPins,
	input  wire logic                    targetClk,
	input  wire logic                    targetPowerSense,
	input  wire logic                    podOsc,
	input  wire logic                    userWaitSelWrite,
	input  wire logic                    userWaitSelData,
	input  wire logic                    irqRequest,
	input  wire run_gate_pkg::access_t   access,
	output run_gate_pkg::route_t         route,
	output logic                         evalResetN,
	output logic                         evalNmiN,
	output logic                         evalReadyN,
	output logic                         evalClkSelInt,
	output logic                         evalClkGate,
	output logic                         waitSelForced,
	output logic                         irqToCpu,
	output logic                         runLed,
	output logic                         powerLed,
	output logic                         resetLed
);

	if (SYNC_STAGES != 3) begin : g_chk
		$error("SYNC_STAGES must be 3");
	end

	// =====================================================================
	// Pin synchronisers: stage 0 is read only by stage 1
	localparam int NPIN = 5;
	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] s0, s1, s2;
	logic [NPIN-1:0] next_s0, next_s1, next_s2;
	logic [NPIN-1:0] pinStable, next_pinStable;
	assign pinRaw = {targetPowerSense, targetClk, targetPins.readyN,
		targetPins.nmiN, targetPins.resetN};

	genvar gi;
	for (gi = 0; gi < NPIN; gi++) begin : g_pin
		always_comb begin
			next_s0[gi] = pinRaw[gi];
			next_s1[gi] = s0[gi];
			next_s2[gi] = s1[gi];
			next_pinStable[gi] = (s1[gi] == s2[gi]) ? s2[gi] : pinStable[gi];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s0 <= 5'h0F;
			s1 <= 5'h0F;
			s2 <= 5'h0F;
			pinStable <= 5'h0F;
		end else begin
			s0 <= next_s0;
			s1 <= next_s1;
			s2 <= next_s2;
			pinStable <= next_pinStable;
		end
	end

	logic pResetN, pNmiN, pReadyN, pClk, pPower;
	assign {pPower, pClk, pReadyN, pNmiN, pResetN} = pinStable;

	// =====================================================================
	// Registers
	logic [31:0] control, next_control;
	logic [19:0] workBase, next_workBase;
	logic        userWaitSel, next_userWaitSel;
	logic        irqPend, next_irqPend;
	logic        tgtRstSeen, next_tgtRstSeen;
	logic [31:0] next_readdata;
	logic        ack, next_ack;
	logic        running;

	assign running = control[run_gate_pkg::CTL_RUN];

	// Waitrequest drops one cycle after the request rises
	always_comb begin
		next_ack = (avs_read | avs_write) & ~ack;
		next_control = control;
		next_workBase = workBase;
		next_userWaitSel = userWaitSel;
		next_readdata = avs_readdata;
		// Writes land at the edge that samples waitrequest low
		if (avs_write && ack) begin
			case (avs_address)
				run_gate_pkg::OFS_CONTROL: next_control = avs_writedata;
				run_gate_pkg::OFS_WORKBASE:
					next_workBase = {avs_writedata[19:1], 1'b0};
				default: ;
			endcase
		end
		if (userWaitSelWrite && running)
			next_userWaitSel = userWaitSelData;
		if (avs_read && !ack) begin
			case (avs_address)
				run_gate_pkg::OFS_CONTROL: next_readdata = control;
				run_gate_pkg::OFS_STATUS: begin
					next_readdata = 32'h0000_0000;
					next_readdata[run_gate_pkg::ST_RUN] = running;
					next_readdata[run_gate_pkg::ST_PWR_LED] = pPower;
					next_readdata[run_gate_pkg::ST_RST_LED] = ~pResetN;
					next_readdata[run_gate_pkg::ST_WAITSEL] = userWaitSel;
					next_readdata[run_gate_pkg::ST_IRQ_PEND] = irqPend;
					next_readdata[run_gate_pkg::ST_TGT_CLK] = pClk;
				end
				run_gate_pkg::OFS_WORKBASE: next_readdata = {12'h000, workBase};
				default: next_readdata = run_gate_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	// Pending request latches while stopped; set wins over the release
	always_comb begin
		next_irqPend = irqPend;
		if (irqRequest && !running)
			next_irqPend = 1'b1;
		else if (running)
			next_irqPend = 1'b0;
		next_tgtRstSeen = running & ~pResetN;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			control <= run_gate_pkg::CONTROL_RESET;
			workBase <= run_gate_pkg::WORKBASE_RESET;
			userWaitSel <= 1'b0;
			irqPend <= 1'b0;
			tgtRstSeen <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			ack <= 1'b0;
		end else begin
			control <= next_control;
			workBase <= next_workBase;
			userWaitSel <= next_userWaitSel;
			irqPend <= next_irqPend;
			tgtRstSeen <= next_tgtRstSeen;
			avs_readdata <= next_readdata;
			ack <= next_ack;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	// =====================================================================
	// Gated target inputs
	assign evalResetN = running ? pResetN : 1'b1;
	assign evalNmiN = running ? pNmiN : 1'b1;
	// Ready is passed only while running; a stopped target must not stall
	assign evalReadyN = running ? pReadyN : 1'b1;

	// Clock source: internal oscillator never gated by run state
	assign evalClkSelInt = control[run_gate_pkg::CTL_CLKINT];
	assign evalClkGate = evalClkSelInt ? podOsc : pClk;

	assign waitSelForced = running ? userWaitSel : 1'b1;
	assign irqToCpu = running & (irqRequest | irqPend);

	assign runLed = running;
	assign powerLed = pPower;
	assign resetLed = tgtRstSeen;

	// =====================================================================
	// Memory routing
	logic inWork, inStack, topInt, mapInt;
	assign inWork = access.addr >= workBase &&
		access.addr < workBase + run_gate_pkg::WORK_SIZE;
	assign inStack = access.addr >= run_gate_pkg::RST_STACK_LO;
	assign topInt = control[run_gate_pkg::CTL_MAPTOP] |
		control[run_gate_pkg::CTL_RSTCMD];
	// SFR area always external, work area internal only where it lies above the SFR area
	assign mapInt = (access.addr > run_gate_pkg::SFR_HI) &&
		(inWork || (access.addr >= run_gate_pkg::MAP_TOP_LO &&
		access.addr <= run_gate_pkg::RST_STACK_HI && topInt));

	always_comb begin
		route = '0;
		if (access.valid) begin
			route.toEmuMem = mapInt;
			route.toTarget = ~mapInt;
			route.workArea = inWork;
			// Seven bytes that debug control may push
			route.stackArea = inStack &&
				access.addr <= run_gate_pkg::RST_STACK_HI;
			route.waitState = ~mapInt & (~access.user | ~running);
		end
	end

	// =====================================================================
	// Checks
	property p_gate_reset;
		@(posedge sys_clk) disable iff (!nrst)
		!running |-> evalResetN && evalNmiN;
	endproperty
	a_gate_reset: assert property (p_gate_reset)
		else $error("target reset or NMI passed while stopped");

	property p_pass_reset;
		@(posedge sys_clk) disable iff (!nrst)
		running |-> evalResetN == pResetN;
	endproperty
	a_pass_reset: assert property (p_pass_reset)
		else $error("target reset not passed while running");

	property p_wait_forced;
		@(posedge sys_clk) disable iff (!nrst)
		!running |-> waitSelForced;
	endproperty
	a_wait_forced: assert property (p_wait_forced)
		else $error("wait select not forced while stopped");

	property p_irq_held;
		@(posedge sys_clk) disable iff (!nrst)
		!running |-> !irqToCpu;
	endproperty
	a_irq_held: assert property (p_irq_held)
		else $error("interrupt reached cpu while stopped");

	property p_irq_resume;
		@(posedge sys_clk) disable iff (!nrst)
		irqPend && !running ##1 running |-> irqToCpu;
	endproperty
	a_irq_resume: assert property (p_irq_resume)
		else $error("pending interrupt not taken on restart");

	property p_clk_int;
		@(posedge sys_clk) disable iff (!nrst)
		evalClkSelInt |-> evalClkGate == podOsc;
	endproperty
	a_clk_int: assert property (p_clk_int)
		else $error("internal clock not passed");

	property p_ack;
		@(posedge sys_clk) disable iff (!nrst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack)
		else $error("waitrequest held beyond one cycle");

	property p_work_int;
		@(posedge sys_clk) disable iff (!nrst)
		access.valid && inWork && access.addr > run_gate_pkg::SFR_HI
			|-> route.toEmuMem;
	endproperty
	a_work_int: assert property (p_work_int)
		else $error("work area not routed to emulation memory");

	property p_write_lands;
		@(posedge sys_clk) disable iff (!nrst)
		avs_write && !avs_waitrequest &&
			avs_address == run_gate_pkg::OFS_CONTROL
			|=> control == $past(avs_writedata);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("control write not taken at the accepting edge");

	property p_irq_pend;
		@(posedge sys_clk) disable iff (!nrst)
		irqRequest && !running |=> irqPend;
	endproperty
	a_irq_pend: assert property (p_irq_pend)
		else $error("request while stopped not kept pending");

	property p_clk_ext;
		@(posedge sys_clk) disable iff (!nrst)
		!evalClkSelInt |-> evalClkGate == pClk;
	endproperty
	a_clk_ext: assert property (p_clk_ext)
		else $error("external clock not followed");

	property p_sfr_ext;
		@(posedge sys_clk) disable iff (!nrst)
		access.valid && access.addr <= run_gate_pkg::SFR_HI
			|-> route.toTarget && !route.toEmuMem;
	endproperty
	a_sfr_ext: assert property (p_sfr_ext)
		else $error("special-function access not routed outward");

	c_run: cover property (@(posedge sys_clk) !running ##1 running);
	c_irq: cover property (@(posedge sys_clk) irqPend ##1 irqToCpu);
	c_rst: cover property (@(posedge sys_clk) running && !evalResetN);
	c_write: cover property (@(posedge sys_clk) avs_write && !avs_waitrequest);
	c_top: cover property (@(posedge sys_clk) access.valid && topInt && mapInt);

endmodule : emulator_run_state_gating

`default_nettype wire

// ---- rtl/run_gate_pkg.sv ----
// Constants and carrier types of the emulator run-state gating block
package run_gate_pkg;

	// =====================================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_WORKBASE = 4'h8;
	localparam logic [3:0] OFS_MAPLOW  = 4'hC;

	// =====================================================================
	// Control field positions
	localparam int CTL_RUN      = 0;
	localparam int CTL_CLKINT   = 1;
	localparam int CTL_WAITSEL  = 2;
	localparam int CTL_RSTCMD   = 3;
	localparam int CTL_MAPTOP   = 4;

	// Status field positions
	localparam int ST_RUN       = 0;
	localparam int ST_PWR_LED   = 1;
	localparam int ST_RST_LED   = 2;
	localparam int ST_WAITSEL   = 3;
	localparam int ST_IRQ_PEND  = 4;
	localparam int ST_TGT_CLK   = 5;

	// =====================================================================
	// Reset values and fixed address figures
	localparam logic [31:0] CONTROL_RESET  = 32'h0000_0002;
	localparam logic [19:0] WORKBASE_RESET = 20'h1_0000;
	localparam logic [19:0] WORK_SIZE      = 20'h0_0020;
	localparam logic [19:0] RST_STACK_LO   = 20'h0_FFF9;
	localparam logic [19:0] RST_STACK_HI   = 20'h0_FFFF;
	localparam logic [19:0] MAP_TOP_LO     = 20'h0_FFF8;
	localparam logic [19:0] SFR_HI         = 20'h0_03FF;
	localparam int          USER_STACK_SPARE = 7;

	// Avalon read data for unmapped offsets
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// =====================================================================
	// Gated target inputs, all active low
	typedef struct packed {
		logic resetN;
		logic nmiN;
		logic readyN;
	} target_in_t;

	// Evaluation processor access request and its routing
	typedef struct packed {
		logic        valid;
		logic        user;
		logic [19:0] addr;
	} access_t;

	typedef struct packed {
		logic toEmuMem;
		logic toTarget;
		logic workArea;
		logic stackArea;
		logic waitState;
	} route_t;

endpackage : run_gate_pkg

// ---- verif/emulator_run_state_gating_tb_top.sv ----
// Self-checking bench of the run-state gating block
`timescale 1ns/1ps
`default_nettype none
module emulator_run_state_gating_tb_top;
	typedef struct packed {logic [31:0] d; logic [31:0] m;} note_t;
	logic sys_clk = '0, nrst = '0, avs_read = '0, avs_write = '0;
	logic podOsc = '0, irqRequest = '0, pinsLow = '0, oscOn = '0;
	logic powerOn = 1'b1, userWaitSelWrite = '0, userWaitSelData = '0;
	logic [3:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic avs_waitrequest, targetClk, targetPowerSense, evalResetN;
	logic evalNmiN, evalReadyN, evalClkSelInt, evalClkGate, waitSelForced;
	logic irqToCpu, runLed, powerLed, resetLed, g, irqSeen = '0;
	run_gate_pkg::target_in_t targetPins;
	run_gate_pkg::access_t access = '0;
	run_gate_pkg::route_t route;
	note_t notes[$];
	note_t nt;
	int n_errors = 0, compares = 0, seed = 77454;
	logic [19:0] base;

	emulator_run_state_gating dut (.sys_clk, .nrst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.targetPins, .targetClk, .targetPowerSense, .podOsc, .userWaitSelWrite,
		.userWaitSelData, .irqRequest, .access, .route, .evalResetN, .evalNmiN,
		.evalReadyN, .evalClkSelInt, .evalClkGate, .waitSelForced, .irqToCpu,
		.runLed, .powerLed, .resetLed);
	target_board_model board (.sys_clk, .running(runLed), .pinsLow, .oscOn,
		.powerOn, .targetPins, .targetClk, .targetPowerSense);

	// ====
	// Clock, oscillator, watchdog
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) podOsc <= ~podOsc;
	initial begin
		#200000;
		n_errors++;
		print_verdict;
	end

	// ====
	// Checking
	task print_verdict;
		if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task fail(input string s);
		n_errors++;
		$display("Error %0t %s", $time, s);
	endtask : fail
	task chk(input logic v, input logic e, input string s);
		compares++;
		if (v !== e) fail(s);
	endtask : chk
	always @(negedge sys_clk) irqSeen <= irqSeen | (irqToCpu === 1'b1);
	// Read data taken at the edge that samples waitrequest low
	always @(posedge sys_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			nt = notes.pop_front();
			compares++;
			if ((avs_readdata & nt.m) !== (nt.d & nt.m)) fail("read data");
		end
	end

	// ====
	// Avalon master and access driver
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{e, m});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task acc(input logic [19:0] a, input logic [4:0] e);
		access <= '{1'b1, 1'b0, a};
		@(negedge sys_clk);
		compares++;
		if (route !== e) fail("route");
		@(posedge sys_clk);
	endtask : acc
	task settle;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	// ====
	// Scenarios
	initial begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		pinsLow <= 1'b1;
		@(posedge sys_clk);
		rd(run_gate_pkg::OFS_CONTROL, run_gate_pkg::CONTROL_RESET, '1);
		rd(run_gate_pkg::OFS_WORKBASE, 32'h10000, 32'hFFFFF);
		rd(4'hC, run_gate_pkg::UNMAPPED_DATA, '1);
		settle;
		chk(evalResetN, 1'b1, "reset passed while stopped");
		chk(evalNmiN, 1'b1, "nmi passed while stopped");
		chk(waitSelForced, 1'b1, "wait not forced");
		chk(powerLed, 1'b1, "power lamp");
		// Base kept clear of the reserved, stack and special areas
		base = {4'h1, 16'($random(seed))};
		bus(1'b1, run_gate_pkg::OFS_WORKBASE, {12'h0, base});
		base[0] = 1'b0;
		rd(run_gate_pkg::OFS_WORKBASE, {12'h0, base}, 32'hFFFFF);
		acc(base, 5'b10100);
		acc(base + 20'h1F, 5'b10100);
		acc(base + 20'h20, 5'b01001);
		acc(20'h003FF, 5'b01001);
		bus(1'b1, run_gate_pkg::OFS_CONTROL, 32'h12);
		acc(run_gate_pkg::MAP_TOP_LO, 5'b10000);
		bus(1'b1, run_gate_pkg::OFS_CONTROL, 32'h1A);
		acc(run_gate_pkg::RST_STACK_LO, 5'b10010);
		bus(1'b1, run_gate_pkg::OFS_CONTROL, 32'h02);
		acc(run_gate_pkg::MAP_TOP_LO, 5'b01001);
		irqRequest <= 1'b1;
		settle;
		@(posedge sys_clk);
		irqRequest <= 1'b0;
		chk(irqSeen, 1'b0, "irq taken while stopped");
		rd(run_gate_pkg::OFS_STATUS, 32'h10, 32'h11);
		bus(1'b1, run_gate_pkg::OFS_CONTROL, 32'h03);
		chk(irqSeen, 1'b1, "pending irq lost");
		settle;
		chk(runLed, 1'b1, "run lamp");
		chk(evalResetN, 1'b0, "reset not passed");
		chk(evalNmiN, 1'b0, "nmi not passed");
		chk(evalReadyN, 1'b0, "ready not passed");
		chk(resetLed, 1'b1, "reset lamp dark");
		@(posedge sys_clk);
		userWaitSelData <= 1'b1;
		userWaitSelWrite <= 1'b1;
		@(posedge sys_clk);
		userWaitSelWrite <= 1'b0;
		userWaitSelData <= 1'b0;
		rd(run_gate_pkg::OFS_STATUS, 32'h9, 32'h9);
		userWaitSelWrite <= 1'b1;
		@(posedge sys_clk);
		userWaitSelWrite <= 1'b0;
		settle;
		chk(waitSelForced, 1'b0, "user wait value");
		bus(1'b1, run_gate_pkg::OFS_CONTROL, 32'h02);
		settle;
		chk(waitSelForced, 1'b1, "wait not forced");
		chk(evalResetN, 1'b1, "reset passed while stopped");
		rd(run_gate_pkg::OFS_STATUS, 32'h0, 32'h9);
		@(negedge sys_clk);
		chk(evalClkGate, podOsc, "internal clock");
		@(negedge sys_clk);
		chk(evalClkGate, podOsc, "internal clock");
		bus(1'b1, run_gate_pkg::OFS_CONTROL, 32'h00);
		settle;
		chk(evalClkSelInt, 1'b0, "clock select");
		g = evalClkGate;
		repeat (3) @(negedge sys_clk);
		chk(evalClkGate, g, "stopped target clock moved");
		@(posedge sys_clk);
		oscOn <= 1'b1;
		settle;
		g = evalClkGate;
		repeat (4) @(negedge sys_clk);
		chk(evalClkGate, ~g, "target clock not followed");
		@(posedge sys_clk);
		powerOn <= 1'b0;
		settle;
		chk(powerLed, 1'b0, "power lamp");
		chk(resetLed, 1'b0, "reset lamp");
		print_verdict;
	end
endmodule : emulator_run_state_gating_tb_top
`default_nettype wire

// ---- verif/target_board_model.sv ----
// Behavioural model of the user target board
`timescale 1ns/1ps
`default_nettype none
module target_board_model (
	input  wire logic                 sys_clk,
	input  wire logic                 running,
	input  wire logic                 pinsLow,
	input  wire logic                 oscOn,
	input  wire logic                 powerOn,
	output run_gate_pkg::target_in_t targetPins,
	output logic                      targetClk,
	output logic                      targetPowerSense
);
	// ====
	// Pins
	// Ready is pulled low only while the program runs
	assign targetPins = '{~pinsLow, ~pinsLow, ~(pinsLow & running)};
	assign targetPowerSense = powerOn;
	// Hold request is not wired out: the board never raises it

	// ====
	// Oscillator: stands still when switched off
	// Slow enough that the pin filter sees each level four times
	logic [1:0] oscDiv = 2'h0;
	initial targetClk = 1'b0;
	always @(posedge sys_clk) begin
		if (oscOn) begin
			oscDiv <= oscDiv + 2'h1;
			if (oscDiv == 2'h3) begin
				targetClk <= ~targetClk;
			end
		end
	end
endmodule : target_board_model
`default_nettype wire
